/* File: acec_pkg.sv */
// package: register map, field layout and mode encodings of the comparator event block
package acec_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses on the plain register port)
    // ------------------------------------------------------------
    localparam logic [3:0] ACEC_ADDR_WIDTH    = 4'h4;
    localparam logic [3:0] ACEC_OFF_CTRL      = 4'h0;  // status and control
    localparam logic [3:0] ACEC_OFF_OPTION    = 4'h4;  // system option two
    localparam logic [3:0] ACEC_OFF_STATE     = 4'h8;  // power state view

    // ------------------------------------------------------------
    // field positions of the status and control register
    // ------------------------------------------------------------
    localparam int ACEC_BIT_ENABLE   = 7;
    localparam int ACEC_BIT_REFSEL   = 6;
    localparam int ACEC_BIT_FLAG     = 5;
    localparam int ACEC_BIT_IRQEN    = 4;
    localparam int ACEC_BIT_LIVE     = 3;
    localparam int ACEC_BIT_OPE      = 2;
    localparam int ACEC_BIT_MODE_HI  = 1;
    localparam int ACEC_BIT_MODE_LO  = 0;
    // field position in system option two
    localparam int ACEC_BIT_ROUTE    = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ACEC_CTRL_RST   = 8'h00;
    localparam logic [7:0] ACEC_OPTION_RST = 8'h00;

    // ------------------------------------------------------------
    // event mode encodings
    // ------------------------------------------------------------
    localparam logic [1:0] ACEC_MODE_FALL0 = 2'h0;
    localparam logic [1:0] ACEC_MODE_RISE  = 2'h1;
    localparam logic [1:0] ACEC_MODE_FALL2 = 2'h2;
    localparam logic [1:0] ACEC_MODE_BOTH  = 2'h3;

    // chip power modes as seen from the power-mode controller
    typedef enum logic [2:0] {
        ACEC_PM_RUN,
        ACEC_PM_WAIT,
        ACEC_PM_LIGHT_STOP,
        ACEC_PM_DEEP_STOP_TWO,
        ACEC_PM_DEEP_STOP_ONE
    } acec_pmode_t;
endpackage : acec_pkg

/* File: acec_sync.sv */
// module: two-flop synchroniser for the asynchronous comparator result
`timescale 1ns/100ps
`default_nettype none
module acec_sync
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic srst,
    // asynchronous level in, synchronised level out
    input  wire logic async_in,
    output var  logic sync_out
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    always_comb
    begin
        meta_nxt = async_in;
        sync_nxt = meta_r;  // first stage is read only here
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule // acec_sync
`default_nettype wire

/* File: acec_top.sv */
// module: control and event logic around the on-chip analog comparator
// How it works
// - enabled comparator keeps evaluating events during light stop
// - in light stop the output pin follows the result as in run
// - event in light stop with irq enable sets flag and requests wake-up
// - reset exit from stop returns all control and status to reset values
// - deep stop powers block down: no evaluation, no flags, no pin drive
// - after deep stop wake-up the status and control settings come up cleared; the routing bit keeps its value
// - background debug halt does not stop normal operation
// - comparator enabled before wait keeps running during wait
// - wait-mode event with irq enable raises an interrupt
// - routing bit sends comparator output to timer capture channel zero
// - routing bit hides timer channel-zero pin from outside
// - events selectable on rising, falling or either edge
// - option replaces positive input pin with internal bandgap
// - option drives comparator result onto output pin
// - mode 00 falling, 01 rising, 10 falling, 11 either edge
// - flag sets on selected event, cleared by writing one, by deep stop or by reset
// - interrupt asserted while flag set and irq enable set
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module acec_top
    import acec_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output var  logic [7:0] reg_rdata,
    // power-mode controller
    input  wire logic [2:0] power_mode,
    input  wire logic       debug_halt,
    input  wire logic       stop_edge_seen,
    output var  logic       wake_req,
    // analog comparator core
    input  wire logic       compare_raw,
    output var  logic       core_power_on,
    output var  logic       reference_select,
    // pins and timer routing
    output var  logic       compare_out_pin,
    output var  logic       compare_out_pin_oe_n,
    output var  logic       timer_capture_in,
    output var  logic       timer_capture_route,
    // interrupt request to the cpu
    output var  logic       compare_irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    logic        route_r;
    logic        route_nxt;
    logic        prev_r;
    logic        prev_nxt;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;
    logic        pin_r;
    logic        pin_nxt;
    logic        pin_oe_n_r;
    logic        pin_oe_n_nxt;
    logic        cap_r;
    logic        cap_nxt;
    logic        irq_r;
    logic        irq_nxt;
    logic        wake_r;
    logic        wake_nxt;
    logic        pwr_r;
    logic        pwr_nxt;
    logic        stop_seen_meta_r;
    logic        stop_seen_r;
    logic        cmp_sync;
    logic        deep_stop;
    logic        enabled;
    logic        evt;
    logic        flag_set;
    logic        flag_clr;
    acec_pmode_t pmode;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // edge selection shared by the clocked and clockless paths
    function automatic logic edge_hit(input logic [1:0] mode,
                                      input logic       rise,
                                      input logic       fall);
        case (mode)
            ACEC_MODE_RISE: edge_hit = rise;
            ACEC_MODE_BOTH: edge_hit = rise | fall;
            default:        edge_hit = fall;  // 00 and 10 both fall
        endcase
    endfunction

    // comparator result brought into the bus clock domain
    acec_sync i_acec_sync
    (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .async_in (compare_raw),
        .sync_out (cmp_sync)
    );

    // ------------------------------------------------------------
    // decode of the power state
    // ------------------------------------------------------------
    // debug halt is deliberately ignored: the block runs on regardless
    always_comb
    begin
        pmode     = acec_pmode_t'(power_mode);
        deep_stop = (pmode == ACEC_PM_DEEP_STOP_TWO) ||
                    (pmode == ACEC_PM_DEEP_STOP_ONE);
        // run, wait, light stop and debug halt all keep the block alive
        enabled   = ctrl_r[ACEC_BIT_ENABLE] & ~deep_stop;
    end

    // ------------------------------------------------------------
    // event detection and flag handling
    // ------------------------------------------------------------
    // without a bus clock the chip-level async latch reports an edge;
    // it arrives synchronised here so it cannot be lost while stopped
    always_comb
    begin
        evt      = edge_hit(ctrl_r[ACEC_BIT_MODE_HI:ACEC_BIT_MODE_LO],
                            cmp_sync & ~prev_r,
                            ~cmp_sync & prev_r);
        // the latch cannot tell rise from fall, so the settled level picks the direction
        flag_set = enabled & (evt | (stop_seen_r &
                   edge_hit(ctrl_r[ACEC_BIT_MODE_HI:ACEC_BIT_MODE_LO],
                            cmp_sync,
                            ~cmp_sync)));
        flag_clr = reg_wr & (reg_addr == ACEC_OFF_CTRL) & reg_wdata[ACEC_BIT_FLAG];
    end

    // ------------------------------------------------------------
    // register next values
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_nxt  = ctrl_r;
        route_nxt = route_r;
        prev_nxt  = enabled ? cmp_sync : 1'b0;
        if (reg_wr && reg_addr == ACEC_OFF_CTRL)
        begin
            ctrl_nxt[ACEC_BIT_ENABLE] = reg_wdata[ACEC_BIT_ENABLE];
            ctrl_nxt[ACEC_BIT_REFSEL] = reg_wdata[ACEC_BIT_REFSEL];
            ctrl_nxt[ACEC_BIT_IRQEN]  = reg_wdata[ACEC_BIT_IRQEN];
            ctrl_nxt[ACEC_BIT_OPE]    = reg_wdata[ACEC_BIT_OPE];
            ctrl_nxt[ACEC_BIT_MODE_HI:ACEC_BIT_MODE_LO] =
                reg_wdata[ACEC_BIT_MODE_HI:ACEC_BIT_MODE_LO];
        end
        if (reg_wr && reg_addr == ACEC_OFF_OPTION)
        begin
            route_nxt = reg_wdata[ACEC_BIT_ROUTE];
        end
        // write-one-to-clear; a same-cycle event wins so it is not lost
        if (flag_clr)
        begin
            ctrl_nxt[ACEC_BIT_FLAG] = 1'b0;
        end
        if (flag_set)
        begin
            ctrl_nxt[ACEC_BIT_FLAG] = 1'b1;
        end
        ctrl_nxt[ACEC_BIT_LIVE] = 1'b0;  // live bit is never stored
        // deep stop clears the status and control register and edge history; the routing bit is kept
        if (deep_stop)
        begin
            ctrl_nxt  = ACEC_CTRL_RST;
            prev_nxt  = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // output and read-back next values
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                ACEC_OFF_CTRL:
                begin
                    rdata_nxt = ctrl_r;
                    rdata_nxt[ACEC_BIT_LIVE] = enabled & cmp_sync;
                end
                ACEC_OFF_OPTION: rdata_nxt = {7'h00, route_r};
                ACEC_OFF_STATE:  rdata_nxt = {5'h00, power_mode};
                default:         rdata_nxt = 8'h00;
            endcase
        end
        // pin follows the result in run, wait and light stop alike
        pin_nxt      = enabled & ctrl_r[ACEC_BIT_OPE] & cmp_sync;
        pin_oe_n_nxt = ~(enabled & ctrl_r[ACEC_BIT_OPE]);
        cap_nxt      = route_r & enabled & cmp_sync;
        irq_nxt      = ctrl_nxt[ACEC_BIT_FLAG] & ctrl_nxt[ACEC_BIT_IRQEN];
        // wake request only matters outside run, so it is gated off there
        wake_nxt     = irq_nxt & (pmode != ACEC_PM_RUN);
        pwr_nxt      = ctrl_nxt[ACEC_BIT_ENABLE] & ~deep_stop;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // srst also covers a reset exit from any stop mode
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ctrl_r           <= ACEC_CTRL_RST;
            route_r          <= ACEC_OPTION_RST[ACEC_BIT_ROUTE];
            prev_r           <= 1'b0;
            rdata_r          <= 8'h00;
            pin_r            <= 1'b0;
            pin_oe_n_r       <= 1'b1;
            cap_r            <= 1'b0;
            irq_r            <= 1'b0;
            wake_r           <= 1'b0;
            pwr_r            <= 1'b0;
            stop_seen_meta_r <= 1'b0;
            stop_seen_r      <= 1'b0;
        end
        else
        begin
            ctrl_r           <= ctrl_nxt;
            route_r          <= route_nxt;
            prev_r           <= prev_nxt;
            rdata_r          <= rdata_nxt;
            pin_r            <= pin_nxt;
            pin_oe_n_r       <= pin_oe_n_nxt;
            cap_r            <= cap_nxt;
            irq_r            <= irq_nxt;
            wake_r           <= wake_nxt;
            pwr_r            <= pwr_nxt;
            stop_seen_meta_r <= stop_edge_seen;
            stop_seen_r      <= stop_seen_meta_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata            = rdata_r;
    assign compare_out_pin      = pin_r;
    assign compare_out_pin_oe_n = pin_oe_n_r;
    assign timer_capture_in     = cap_r;
    assign timer_capture_route  = route_r;
    assign compare_irq          = irq_r;
    assign wake_req             = wake_r;
    assign core_power_on        = pwr_r;
    assign reference_select     = ctrl_r[ACEC_BIT_REFSEL];
endmodule // acec_top
`default_nettype wire

/* File: acec_top_asserts.sv */
// checker: port-level properties of the comparator event block
`timescale 1ns/100ps
`default_nettype none
module acec_top_asserts
    import acec_pkg::*;
(
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       srst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // power controller and core
    input wire logic [2:0] power_mode,
    input wire logic       debug_halt,
    input wire logic       stop_edge_seen,
    input wire logic       wake_req,
    input wire logic       compare_raw,
    input wire logic       core_power_on,
    input wire logic       reference_select,
    // pins, timer and interrupt
    input wire logic       compare_out_pin,
    input wire logic       compare_out_pin_oe_n,
    input wire logic       timer_capture_in,
    input wire logic       timer_capture_route,
    input wire logic       compare_irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    // three cycles of deep stop leave core, pin and request quiet
    deep_off_a: assert property (
        (power_mode inside {ACEC_PM_DEEP_STOP_TWO, ACEC_PM_DEEP_STOP_ONE})[*3]
        |=> !core_power_on && !compare_out_pin && !compare_irq) else $error("deep stop not quiet");
    // no wake request is raised from run
    run_no_wake_a: assert property (
        power_mode == ACEC_PM_RUN |=> !wake_req) else $error("wake request in run");
    // a wake request always stems from a pending interrupt
    wake_cause_a: assert property (
        wake_req |-> compare_irq) else $error("wake request without interrupt");
    // pending interrupt in wait or light stop asks for wake-up
    stop_wake_a: assert property (
        compare_irq && $past(power_mode) inside {ACEC_PM_WAIT, ACEC_PM_LIGHT_STOP}
        |-> wake_req) else $error("no wake request");
    // pin level only shows while the pin is driven
    pin_drive_a: assert property (
        compare_out_pin |-> !compare_out_pin_oe_n) else $error("pin high while released");
    // result reaches the pin through two sync stages and the pin flop
    pin_sync_a: assert property (
        $rose(compare_out_pin) |-> $past(compare_raw, 3)) else $error("pin ahead of sync");
    // live bit reads low while the block is disabled
    live_off_a: assert property (
        (reg_rd && reg_addr == ACEC_OFF_CTRL) ##1 !reg_rdata[ACEC_BIT_ENABLE]
        |-> !reg_rdata[ACEC_BIT_LIVE]) else $error("live bit set while disabled");
    // flag with interrupt enable read back means a raised request
    irq_flag_a: assert property (
        (reg_rd && reg_addr == ACEC_OFF_CTRL) ##1
        (reg_rdata[ACEC_BIT_FLAG] && reg_rdata[ACEC_BIT_IRQEN])
        |-> compare_irq) else $error("interrupt missing");
    // capture input stays low unless routing was on
    route_gate_a: assert property (
        !$past(timer_capture_route) |-> !timer_capture_in) else $error("capture without route");

    cover property ($rose(wake_req));
    cover property ($rose(timer_capture_in));
    cover property ($fell(compare_out_pin_oe_n));
endmodule // acec_top_asserts
`default_nettype wire

/* File: acec_partner.sv */
// partner: comparator core and power-mode controller model
`timescale 1ns/100ps
`default_nettype none
module acec_partner
    import acec_pkg::*;
#(
    parameter logic [7:0] BANDGAP_LVL = 8'h80  // arbitrary reference level
)
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       srst,
    // levels and mode asked by the bench
    input  wire logic [7:0] pos_lvl,
    input  wire logic [7:0] neg_lvl,
    input  wire logic [2:0] mode_req,
    // block side
    input  wire logic       core_power_on,
    input  wire logic       reference_select,
    input  wire logic       wake_req,
    output var  logic       compare_raw,
    output var  logic       stop_edge_seen,
    output var  logic [2:0] power_mode
);
    logic raw_d_r;
    logic woke_r;

    // unpowered core output sits low; bandgap replaces the positive pin
    always_comb
    begin
        compare_raw = core_power_on && ((reference_select ? BANDGAP_LVL : pos_lvl) > neg_lvl);
    end

    // a wake holds the chip in run until the bench itself asks for run
    always_ff @(posedge ref_clk)
    begin
        raw_d_r <= compare_raw;
        woke_r <= !srst && mode_req != ACEC_PM_RUN && (woke_r || wake_req);
        power_mode <= (srst || woke_r || wake_req) ? ACEC_PM_RUN : mode_req;
        // edge latch of light stop, dropped once the chip leaves it
        stop_edge_seen <= !srst && power_mode == ACEC_PM_LIGHT_STOP
            && (stop_edge_seen || (core_power_on && compare_raw != raw_d_r));
    end
endmodule // acec_partner
`default_nettype wire

/* File: tb.sv */
// testbench: drives the comparator event block and checks its answers
`timescale 1ns/100ps
`default_nettype none
module tb
    import acec_pkg::*;
;
    logic        ref_clk, stop_edge_seen, wake_req, compare_raw, core_power_on;
    logic        reference_select, compare_out_pin, compare_out_pin_oe_n;
    logic        timer_capture_in, timer_capture_route, compare_irq;
    logic        srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, debug_halt = 1'b0, rd_p = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00, pos_lvl = 8'h00, neg_lvl = 8'h40, reg_rdata;
    logic [2:0]  power_mode, mode_req = ACEC_PM_RUN;
    logic [7:0]  exp_q[$];
    logic [31:0] seed = 32'h606B;
    int          mismatches, n_tests;

    acec_top i_acec_top
    (
        .ref_clk              (ref_clk),
        .srst                 (srst),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata),
        .power_mode           (power_mode),
        .debug_halt           (debug_halt),
        .stop_edge_seen       (stop_edge_seen),
        .wake_req             (wake_req),
        .compare_raw          (compare_raw),
        .core_power_on        (core_power_on),
        .reference_select     (reference_select),
        .compare_out_pin      (compare_out_pin),
        .compare_out_pin_oe_n (compare_out_pin_oe_n),
        .timer_capture_in     (timer_capture_in),
        .timer_capture_route  (timer_capture_route),
        .compare_irq          (compare_irq)
    );
    acec_partner i_acec_partner
    (
        .ref_clk          (ref_clk),
        .srst             (srst),
        .pos_lvl          (pos_lvl),
        .neg_lvl          (neg_lvl),
        .mode_req         (mode_req),
        .core_power_on    (core_power_on),
        .reference_select (reference_select),
        .wake_req         (wake_req),
        .compare_raw      (compare_raw),
        .stop_edge_seen   (stop_edge_seen),
        .power_mode       (power_mode)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // the read answer is noted now and compared when it stands
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask

    // random level well above the fixed negative input, or below it
    task automatic lvl(input logic hi);
        logic [31:0] r;
        r = xs();
        @(posedge ref_clk);
        pos_lvl <= hi ? {1'b1, r[6:0]} : {2'b00, r[5:0]};
    endtask

    task automatic complete_run;
        // a read noted but never answered counts against the run
        if (exp_q.size() != 0)
            mismatches++;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // oldest noted read is compared in the cycle after its strobe
    always @(posedge ref_clk)
    begin
        if (rd_p)
            chk("reg_rdata", reg_rdata, exp_q.pop_front());
        rd_p <= reg_rd;
    end

    // the whole sequence needs about 250 cycles; the limit lies at 20000
    initial
    begin
        #(4 * 20000);
        mismatches++;
        complete_run;
    end

    initial
    begin
        logic [31:0] r;
        cyc(5);
        srst <= 1'b0;
        rd(ACEC_OFF_CTRL, ACEC_CTRL_RST);
        rd(ACEC_OFF_OPTION, ACEC_OPTION_RST);
        rd(4'hC, 8'h00);
        chk("oe_n", compare_out_pin_oe_n, 1);
        $display("test reset done");
        // every event mode, with a debug halt on the last pass
        for (int m = 0; m < 4; m++)
        begin
            debug_halt <= (m == 3);
            wr(ACEC_OFF_CTRL, 8'h80 | 8'(m));
            lvl(1);
            cyc(8);
            rd(ACEC_OFF_CTRL, (m % 2) ? 8'hA8 | 8'(m) : 8'h88 | 8'(m));
            wr(ACEC_OFF_CTRL, 8'hA0 | 8'(m));
            rd(ACEC_OFF_CTRL, 8'h88 | 8'(m));
            lvl(0);
            cyc(8);
            rd(ACEC_OFF_CTRL, (m == 1) ? 8'h81 : 8'hA0 | 8'(m));
            wr(ACEC_OFF_CTRL, 8'h20);
        end
        $display("test modes done");
        // comparator kept on as the wake source of wait
        wr(ACEC_OFF_CTRL, 8'h91);
        mode_req <= ACEC_PM_WAIT;
        lvl(1);
        cyc(8);
        chk("irq", compare_irq, 1);
        chk("mode", power_mode, ACEC_PM_RUN);
        mode_req <= ACEC_PM_RUN;
        wr(ACEC_OFF_CTRL, 8'hB1);
        cyc(2);
        chk("irq", compare_irq, 0);
        $display("test wait done");
        wr(ACEC_OFF_CTRL, 8'h85);
        mode_req <= ACEC_PM_LIGHT_STOP;
        lvl(0);
        cyc(8);
        chk("oe_n", compare_out_pin_oe_n, 0);
        rd(ACEC_OFF_CTRL, 8'h85);
        lvl(1);
        cyc(8);
        chk("pin", compare_out_pin, 1);
        chk("mode", power_mode, ACEC_PM_LIGHT_STOP);
        wr(ACEC_OFF_CTRL, 8'h95);
        cyc(6);
        chk("mode", power_mode, ACEC_PM_RUN);
        mode_req <= ACEC_PM_RUN;
        rd(ACEC_OFF_CTRL, 8'hBD);
        $display("test light stop done");
        wr(ACEC_OFF_OPTION, 8'h01);
        cyc(4);
        chk("route", timer_capture_route, 1);
        chk("capture", timer_capture_in, 1);
        lvl(0);
        cyc(6);
        chk("capture", timer_capture_in, 0);
        $display("test route done");
        // bandgap buffer is taken as already on before each pick
        repeat (4)
        begin
            r = xs();
            wr(ACEC_OFF_CTRL, {1'b1, r[0], 6'h00});
            cyc(3);
            chk("refsel", reference_select, r[0]);
        end
        for (int d = 3; d < 5; d++)
        begin
            wr(ACEC_OFF_CTRL, 8'hA4);
            mode_req <= 3'(d);
            cyc(6);
            chk("core", core_power_on, 0);
            chk("oe_n", compare_out_pin_oe_n, 1);
            mode_req <= ACEC_PM_RUN;
            rd(ACEC_OFF_CTRL, 8'h00);
            rd(ACEC_OFF_OPTION, 8'h01);
        end
        $display("test deep stop done");
        // reset taken while in light stop
        wr(ACEC_OFF_CTRL, 8'hD5);
        mode_req <= ACEC_PM_LIGHT_STOP;
        cyc(2);
        srst <= 1'b1;
        cyc(2);
        srst <= 1'b0;
        mode_req <= ACEC_PM_RUN;
        rd(ACEC_OFF_CTRL, 8'h00);
        rd(ACEC_OFF_OPTION, 8'h00);
        chk("refsel", reference_select, 0);
        cyc(2);
        $display("test stop reset done");
        complete_run;
    end
endmodule // tb

bind acec_top acec_top_asserts i_acec_top_asserts
(
    .ref_clk              (ref_clk),
    .srst                 (srst),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .power_mode           (power_mode),
    .debug_halt           (debug_halt),
    .stop_edge_seen       (stop_edge_seen),
    .wake_req             (wake_req),
    .compare_raw          (compare_raw),
    .core_power_on        (core_power_on),
    .reference_select     (reference_select),
    .compare_out_pin      (compare_out_pin),
    .compare_out_pin_oe_n (compare_out_pin_oe_n),
    .timer_capture_in     (timer_capture_in),
    .timer_capture_route  (timer_capture_route),
    .compare_irq          (compare_irq)
);
`default_nettype wire
